// file: hdl/holdover_counters.sv
// holdover prescaler, hold-off counter and per-input revalidation counters
// assumes clk is the vcxo-pll output; reference inputs are asynchronous pins
// Function
// - prescaler divides clock by 2^15, 2^16 or 2^17 for settings 00, 01, 10.
// - each reference input keeps its own revalidation counter of valid periods.
// - counter decrements by one per valid consecutive input period.
// - a missing edge for one period while revalidating reloads the full count.
// - counter reaching zero marks input revalidated and clears its loss flag.
// - length setting 00=2, 01=16, 10=32, 11=64 periods; reset setting 10.
// - hold-off counter runs on prescaler ticks after loss, fails over on the tick taken at one (not zero), reloads.
`timescale 1ns/10ps
module holdover_counters #(
	parameter int N_REF = 2,
	parameter int GAP_W = 8,
	parameter logic [GAP_W-1:0] GAP_LIMIT = 8'h40
) (
	input wire logic clk, // vcxo-pll output clock, 40 MHz nominal
	input wire logic arst_n, // async reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic [N_REF-1:0] ref_clk_in, // reference input pins
	input wire logic cfg_wr, // write strobe for the settings below
	input wire logic [1:0] holdover_prescale_select_in, // prescaler setting to write
	input wire logic [1:0] revalidation_length_select_in, // length setting to write
	input wire logic [7:0] holdoff_count_value_in, // hold-off value to write
	input wire logic [$clog2(N_REF)-1:0] active_ref, // input watched by the hold-off counter
	output logic [1:0] holdover_prescale_select, // prescaler setting readback
	output logic [1:0] revalidation_length_select, // length setting readback
	output logic [7:0] holdoff_count_value, // hold-off value readback
	output logic [N_REF-1:0] signal_loss_flag, // per-input loss flags
	output logic [N_REF-1:0] revalidated, // per-input revalidation pulse
	output logic holdoff_tick, // prescaler tick pulse
	output logic [7:0] holdoff_remaining, // hold-off counter value
	output logic failover // pulse requesting a reference switch
);
	logic [N_REF-1:0] sync1_q, sync2_q, sync3_q;
	logic [holdover_pkg::PRESC_W-1:0] presc_q;
	holdover_pkg::hold_state_t state_q, state_d;
	logic [7:0] hold_d;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			holdover_prescale_select <= holdover_pkg::PRESC_SEL_RST;
			revalidation_length_select <= holdover_pkg::REVAL_SEL_RST;
			holdoff_count_value <= holdover_pkg::HOLDOFF_RST;
		end else if (ce && cfg_wr) begin
			holdover_prescale_select <= holdover_prescale_select_in;
			revalidation_length_select <= revalidation_length_select_in;
			holdoff_count_value <= holdoff_count_value_in;
		end
	end

	// all three settings move together, so a half-written pair is never seen
	a_cfg_load: assert property (@(posedge clk) disable iff (!arst_n)
		ce && cfg_wr |=> holdover_prescale_select == $past(holdover_prescale_select_in) &&
		revalidation_length_select == $past(revalidation_length_select_in) &&
		holdoff_count_value == $past(holdoff_count_value_in))
		else $error("settings not loaded by the write strobe");
	a_cfg_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!(ce && cfg_wr) |=> $stable(holdover_prescale_select) &&
		$stable(revalidation_length_select) && $stable(holdoff_count_value))
		else $error("settings changed without an enabled write");

	// two flops resynchronise the pins; the third only feeds the edge detector
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else if (ce) begin
			sync1_q <= ref_clk_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// the edge detector must see the resynchronised copy, never the raw pin
	a_sync_chain: assert property (@(posedge clk) disable iff (!arst_n)
		ce |=> sync2_q == $past(sync1_q) && sync3_q == $past(sync2_q))
		else $error("resynchroniser stages did not advance");

	wire [N_REF-1:0] ref_edge = sync2_q & ~sync3_q;
	wire [holdover_pkg::REVAL_W-1:0] reval_load =
		holdover_pkg::reval_count(revalidation_length_select);

	// the missing-edge window must exceed the slowest valid reference period
	for (genvar i = 0; i < N_REF; i++) begin : g_ch
		reval_channel #(.GAP_W(GAP_W)) u_ch (
			.clk(clk),
			.arst_n(arst_n),
			.ce(ce),
			.ref_edge(ref_edge[i]),
			.gap_limit(GAP_LIMIT),
			.load_count(reval_load),
			.los_q(signal_loss_flag[i]),
			.reval_q(revalidated[i]),
			.count_q()
		);
	end

	// the free-running prescaler is shared; a setting change alters the wrap compare at once, in the middle of a count
	wire [holdover_pkg::PRESC_W-1:0] presc_lim = holdover_pkg::presc_mask(holdover_prescale_select);
	wire presc_wrap = ((presc_q & presc_lim) == presc_lim);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_q <= '0;
			holdoff_tick <= 1'b0;
		end else if (ce) begin
			presc_q <= presc_wrap ? '0 : presc_q + holdover_pkg::PRESC_W'(1);
			holdoff_tick <= presc_wrap;
		end
	end

	// a tick wider than one cycle would step the hold-off counter twice
	a_tick_pulse: assert property (@(posedge clk) disable iff (!arst_n)
		ce && holdoff_tick |=> !holdoff_tick)
		else $error("prescaler tick lasted more than one cycle");
	a_ce_freeze: assert property (@(posedge clk) disable iff (!arst_n)
		!ce |=> $stable(presc_q) && $stable(holdoff_tick) && $stable(state_q) &&
		$stable(holdoff_remaining) && $stable(failover) && $stable(signal_loss_flag))
		else $error("state moved while the clock enable was low");

	// only the watched input is timed; the other input's loss is reported but not timed
	wire watched_loss = signal_loss_flag[active_ref];
	wire hold_zero = (holdoff_remaining <= 8'h01);
	wire fire = (state_q == holdover_pkg::HOLD_RUN) && holdoff_tick && hold_zero;

	always_comb begin
		state_d = state_q;
		hold_d = holdoff_remaining;
		case (state_q)
			holdover_pkg::HOLD_IDLE: begin
				hold_d = holdoff_count_value;
				if (watched_loss) begin
					state_d = holdover_pkg::HOLD_RUN;
				end
			end
			holdover_pkg::HOLD_RUN: begin
				if (!watched_loss) begin
					state_d = holdover_pkg::HOLD_IDLE;
					hold_d = holdoff_count_value;
				end else if (fire) begin
					hold_d = holdoff_count_value;
				end else if (holdoff_tick) begin
					hold_d = holdoff_remaining - 8'h01;
				end
			end
			default: begin
				state_d = holdover_pkg::HOLD_IDLE;
				hold_d = holdoff_count_value;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= holdover_pkg::HOLD_IDLE;
			holdoff_remaining <= holdover_pkg::HOLDOFF_RST;
			failover <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			holdoff_remaining <= hold_d;
			failover <= fire && watched_loss;
		end
	end

	a_presc_period: assert property (@(posedge clk) disable iff (!arst_n)
		ce && presc_wrap |=> presc_q == 17'h00000 && holdoff_tick)
		else $error("prescaler did not wrap on its limit");
	a_presc_reserved: assert property (@(posedge clk) disable iff (!arst_n)
		holdover_prescale_select == 2'h3 |-> presc_lim == 17'h1ffff)
		else $error("reserved prescaler code not treated as divide by 2^17");
	a_reval_table: assert property (@(posedge clk) disable iff (!arst_n)
		(revalidation_length_select == 2'h0 |-> reval_load == 7'h02) and
		(revalidation_length_select == 2'h3 |-> reval_load == 7'h40))
		else $error("revalidation length decode wrong");
	a_hold_step: assert property (@(posedge clk) disable iff (!arst_n)
		ce && state_q == holdover_pkg::HOLD_RUN && watched_loss && holdoff_tick && !hold_zero
		|=> holdoff_remaining == $past(holdoff_remaining) - 8'h01)
		else $error("hold-off counter did not step on tick");
	a_hold_fire: assert property (@(posedge clk) disable iff (!arst_n)
		ce && fire && watched_loss |=> failover && holdoff_remaining == $past(holdoff_count_value))
		else $error("hold-off expiry did not fail over and reload");
	a_hold_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == holdover_pkg::HOLD_IDLE |=> !failover)
		else $error("fail-over raised while no loss");

	// idle tracks the programmed value so that a new loss starts from a full count
	a_idle_reload: assert property (@(posedge clk) disable iff (!arst_n)
		ce && state_q == holdover_pkg::HOLD_IDLE
		|=> holdoff_remaining == $past(holdoff_count_value))
		else $error("idle hold-off counter not tracking its setting");
	a_enter_run: assert property (@(posedge clk) disable iff (!arst_n)
		ce && state_q == holdover_pkg::HOLD_IDLE && watched_loss
		|=> state_q == holdover_pkg::HOLD_RUN)
		else $error("hold-off counter did not start after loss");
	a_leave_run: assert property (@(posedge clk) disable iff (!arst_n)
		ce && state_q == holdover_pkg::HOLD_RUN && !watched_loss
		|=> state_q == holdover_pkg::HOLD_IDLE && !failover)
		else $error("hold-off counter kept running after revalidation");
	a_run_hold: assert property (@(posedge clk) disable iff (!arst_n)
		ce && state_q == holdover_pkg::HOLD_RUN && watched_loss && !holdoff_tick
		|=> holdoff_remaining == $past(holdoff_remaining))
		else $error("hold-off counter moved without a tick");
	a_fail_pulse: assert property (@(posedge clk) disable iff (!arst_n)
		ce && failover |=> !failover)
		else $error("fail-over lasted more than one cycle");
	a_fail_on_tick: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(failover) |-> $past(holdoff_tick) && $past(watched_loss))
		else $error("fail-over raised without a tick during loss");

	// a revalidation pulse never stands beside a loss flag of the same input
	a_reval_clears: assert property (@(posedge clk) disable iff (!arst_n)
		(revalidated & signal_loss_flag) == '0)
		else $error("revalidation pulse while the loss flag is set");
	a_reval_once: assert property (@(posedge clk) disable iff (!arst_n)
		ce && |revalidated |=> (revalidated & $past(revalidated)) == '0)
		else $error("revalidation pulse lasted more than one cycle");
endmodule : holdover_counters

// file: hdl/holdover_pkg.sv
// constants for the holdover prescaler and the per-input revalidation counters
// assumes a single clock domain driven by the vcxo-pll output
package holdover_pkg;
	localparam logic [1:0] PRESC_SEL_RST = 2'h2;
	localparam logic [1:0] REVAL_SEL_RST = 2'h2;
	localparam logic [7:0] HOLDOFF_RST = 8'h80;
	localparam int PRESC_W = 17;
	localparam int PRESC_EXP_00 = 15;
	localparam int PRESC_EXP_01 = 16;
	localparam int PRESC_EXP_10 = 17;
	localparam int REVAL_W = 7;
	localparam logic [6:0] REVAL_CNT_00 = 7'h02;
	localparam logic [6:0] REVAL_CNT_01 = 7'h10;
	localparam logic [6:0] REVAL_CNT_10 = 7'h20;
	localparam logic [6:0] REVAL_CNT_11 = 7'h40;

	typedef enum logic [0:0] {
		HOLD_IDLE = 1'b0,
		HOLD_RUN = 1'b1
	} hold_state_t;

	// code 11 is reserved and behaves as the reset divider
	function automatic logic [PRESC_W-1:0] presc_mask(input logic [1:0] sel);
		case (sel)
			2'h0: presc_mask = PRESC_W'((1 << PRESC_EXP_00) - 1);
			2'h1: presc_mask = PRESC_W'((1 << PRESC_EXP_01) - 1);
			default: presc_mask = PRESC_W'((1 << PRESC_EXP_10) - 1);
		endcase
	endfunction : presc_mask

	function automatic logic [REVAL_W-1:0] reval_count(input logic [1:0] sel);
		case (sel)
			2'h0: reval_count = REVAL_CNT_00;
			2'h1: reval_count = REVAL_CNT_01;
			2'h2: reval_count = REVAL_CNT_10;
			default: reval_count = REVAL_CNT_11;
		endcase
	endfunction : reval_count
endpackage : holdover_pkg

// file: hdl/reval_channel.sv
// one input's loss detector and revalidation counter
// assumes ref_edge is a one-cycle pulse already synchronised to clk
`timescale 1ns/10ps
module reval_channel #(
	parameter int GAP_W = 8
) (
	input wire logic clk, // vcxo-pll clock
	input wire logic arst_n, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic ref_edge, // rising edge seen on the input
	input wire logic [GAP_W-1:0] gap_limit, // cycles without edge that count as missing
	input wire logic [holdover_pkg::REVAL_W-1:0] load_count, // programmed revalidation count
	output logic los_q, // loss flag
	output logic reval_q, // pulse when the input is revalidated
	output logic [holdover_pkg::REVAL_W-1:0] count_q // remaining valid periods
);
	logic [GAP_W-1:0] gap_q;
	wire missing = (gap_q >= gap_limit);
	wire last_period = (count_q == holdover_pkg::REVAL_W'(1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_q <= '0;
		end else if (ce) begin
			gap_q <= (ref_edge || missing) ? '0 : gap_q + GAP_W'(1);
		end
	end

	// a missing edge outranks a good one in the same cycle, so loss is never lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			los_q <= 1'b1;
			reval_q <= 1'b0;
			count_q <= holdover_pkg::REVAL_CNT_10;
		end else if (ce) begin
			reval_q <= 1'b0;
			if (missing) begin
				los_q <= 1'b1;
				count_q <= load_count;
			end else if (los_q && ref_edge) begin
				count_q <= count_q - holdover_pkg::REVAL_W'(1);
				if (last_period) begin
					los_q <= 1'b0;
					reval_q <= 1'b1;
				end
			end
		end
	end

	a_reload_on_gap: assert property (@(posedge clk) disable iff (!arst_n)
		ce && missing |=> los_q && count_q == $past(load_count))
		else $error("revalidation count not reloaded after missing edge");
	a_single_step: assert property (@(posedge clk) disable iff (!arst_n)
		ce && los_q && ref_edge && !missing |=> count_q == $past(count_q) - 7'h01)
		else $error("revalidation count did not step by one");
	a_clear_at_zero: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(los_q) |-> reval_q && count_q == 7'h00)
		else $error("loss flag cleared without reaching zero");
	a_hold_no_edge: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !ref_edge && !missing |=> count_q == $past(count_q) && los_q == $past(los_q))
		else $error("revalidation state moved without an edge");
endmodule : reval_channel

// file: test/test_holdover_counters.sv
// self-checking bench for holdover_counters: settings, revalidation and prescaler
// assumes the design files under hdl/ are compiled first
`timescale 1ns/10ps
module test_holdover_counters;
	typedef struct packed {logic [1:0] sel; logic [6:0] cnt; logic [1:0] ps;} row_t;
	row_t rows [4] = '{'{2'h0, 7'h02, 2'h3}, '{2'h1, 7'h10, 2'h2}, '{2'h2, 7'h20, 2'h1},
		'{2'h3, 7'h40, 2'h0}};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic [1:0] ref_clk_in = 2'h0;
	logic cfg_wr = 1'b0;
	logic [1:0] psel = 2'h2;
	logic [1:0] lsel = 2'h2;
	logic [7:0] hval = 8'h80;
	logic [0:0] active_ref = 1'h0;
	logic [1:0] p_rb, l_rb, loss, reval;
	logic [7:0] h_rb, h_rem;
	logic tick, fov;
	int fails = 0;
	int n_compared = 0;
	int seen = 0;
	int r0, n, f;
	holdover_counters uut (.clk(clk), .arst_n(arst_n), .ce(ce), .ref_clk_in(ref_clk_in),
		.cfg_wr(cfg_wr), .holdover_prescale_select_in(psel),
		.revalidation_length_select_in(lsel), .holdoff_count_value_in(hval),
		.active_ref(active_ref), .holdover_prescale_select(p_rb),
		.revalidation_length_select(l_rb), .holdoff_count_value(h_rb),
		.signal_loss_flag(loss), .revalidated(reval), .holdoff_tick(tick),
		.holdoff_remaining(h_rem), .failover(fov));
	always #12.5 clk = ~clk;
	always @(posedge clk) if (reval[0] === 1'b1) seen <= seen + 1;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task end_sim;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	task cfg(input logic [1:0] p, input logic [1:0] l, input logic [7:0] h);
		@(posedge clk);
		psel <= p;
		lsel <= l;
		hval <= h;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		repeat (80) @(posedge clk); // quiet long enough for a missing-edge load
		@(negedge clk);
	endtask : cfg
	// edge period of 8 cycles stays well inside the missing-edge window
	task edges(input int k);
		repeat (k) begin
			@(posedge clk) ref_clk_in[0] <= 1'b1;
			repeat (4) @(posedge clk);
			ref_clk_in[0] <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask : edges
	task wait_tick;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (fov === 1'b1) f++;
		end while (tick !== 1'b1 && n < 40000);
		if (n >= 40000) begin
			fails++;
			end_sim;
		end
	endtask : wait_tick
	initial begin
		repeat (5) @(negedge clk);
		chk({p_rb, l_rb, h_rb}, {2'h2, 2'h2, 8'h80});
		chk({loss, h_rem}, {2'h3, 8'h80});
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			cfg(rows[i].ps, rows[i].sel, 8'h80);
			chk({p_rb, l_rb, h_rb}, {rows[i].ps, rows[i].sel, 8'h80});
			chk(loss[0], 1'b1);
			r0 = seen;
			edges(rows[i].cnt - 1);
			chk({loss[0], 16'(seen)}, {1'b1, 16'(r0)});
			edges(1);
			chk({loss[0], 16'(seen)}, {1'b0, 16'(r0 + 1)});
			chk(loss[1], 1'b1);
			$display("row %0d done", i);
		end
		cfg(2'h0, 2'h1, 8'h01);
		edges(5);
		repeat (80) @(negedge clk);
		edges(15);
		chk(loss[0], 1'b1);
		edges(1);
		chk(loss[0], 1'b0);
		$display("reload test done");
		repeat (80) @(negedge clk);
		f = 0;
		wait_tick;
		f = 0;
		wait_tick;
		chk(n, 32768);
		chk(f, 1);
		$display("prescaler test done");
		@(posedge clk) ce <= 1'b0;
		cfg(2'h1, 2'h0, 8'h22);
		chk({p_rb, l_rb, h_rb, loss}, {2'h0, 2'h1, 8'h01, 2'h3});
		@(posedge clk) ce <= 1'b1;
		$display("clock enable test done");
		@(posedge clk) arst_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk({p_rb, l_rb, h_rb}, {2'h2, 2'h2, 8'h80});
		chk({loss, h_rem, tick, fov}, {2'h3, 8'h80, 2'h0});
		@(posedge clk) arst_n <= 1'b1;
		cfg(2'h1, 2'h3, 8'h05);
		chk({p_rb, l_rb, h_rb, loss, h_rem}, {2'h1, 2'h3, 8'h05, 2'h3, 8'h80});
		$display("mid-run reset test done");
		end_sim;
	end
endmodule : test_holdover_counters
